//--- core/mmc_defines.svh
// Register offsets, bit positions, reset values and address limits for the memory map configuration block
`ifndef MMC_DEFINES_SVH
`define MMC_DEFINES_SVH

`define MMC_ADDR_W           8
`define MMC_OFS_AUX_MEM      8'h8E
`define MMC_OFS_AUX_BOOT     8'hA2
`define MMC_OFS_CODE_MAP     8'hD1

`define MMC_BIT_PULLUP_DIS   7
`define MMC_BIT_RAM_SIZE     2
`define MMC_BIT_EXT_DATA     1
`define MMC_BIT_LATCH_GATE   0
`define MMC_BIT_BOOT_EN      5
`define MMC_BIT_USER_FLAG    3
`define MMC_BIT_ZERO         2
`define MMC_BIT_PTR_SEL      0
`define MMC_BIT_CODE_MAP     3

`define MMC_RST_BOOT_EN      1'b1
`define MMC_RAM_END_SMALL    16'h00FF
`define MMC_RAM_END_LARGE    16'h01FF
`define MMC_CODE_TOP_LOW     16'h7FFF

`define MMC_STROBE_DIV_X1    3'h6
`define MMC_STROBE_DIV_X2    3'h3

`endif

//--- core/mmc_pkg.sv
// Types shared by the memory map configuration block
package mmc_pkg;

  typedef enum logic [1:0] {
    MMC_DST_INT_RAM  = 2'b00,
    MMC_DST_EXT_DATA = 2'b01,
    MMC_DST_CODE_RAM = 2'b10
  } mmc_data_dst_t;

  typedef enum logic [1:0] {
    MMC_FETCH_LOW_CODE = 2'b00,
    MMC_FETCH_BOOT_ROM = 2'b01,
    MMC_FETCH_EXT_CODE = 2'b10
  } mmc_fetch_dst_t;

endpackage

//--- core/mmc_cfg_bit.sv
// One software-writable configuration bit with its own reset value
`timescale 1ns/1ps
`default_nettype none

module mmc_cfg_bit #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  input  wire logic load_i,
  input  wire logic din_i,
  output var  logic q_o
);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_o <= RST_VAL;
    end else if (ce_i && load_i) begin
      q_o <= din_i;
    end
  end

endmodule // mmc_cfg_bit

`default_nettype wire

//--- core/mmc_strobe_gen.sv
// Address latch strobe generator: free-running divider or per-instruction pulse
`timescale 1ns/1ps
`default_nettype none

`include "mmc_defines.svh"

module mmc_strobe_gen (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  input  wire logic gate_i,
  input  wire logic double_speed_i,
  input  wire logic ext_access_i,
  output var  logic strobe_o
);

  logic [2:0] cnt_r;
  logic [2:0] div;

  assign div = double_speed_i ? `MMC_STROBE_DIV_X2 : `MMC_STROBE_DIV_X1;

  // One pulse per divider period; counter restarts whenever the strobe is gated
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= 3'h0;
    end else if (ce_i) begin
      if (gate_i || cnt_r >= div - 3'h1) begin
        cnt_r <= 3'h0;
      end else begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strobe_o <= 1'b0;
    end else if (ce_i) begin
      if (gate_i) begin
        strobe_o <= ext_access_i;
      end else begin
        strobe_o <= (cnt_r == 3'h0);
      end
    end
  end

endmodule // mmc_strobe_gen

`default_nettype wire

//--- core/mmc_memory_map_regs.sv
// Memory map configuration registers of the core and the routing they steer
//
// Summary of operation
// - Aux control bit 7 set disables port weak pull-ups.
// - Aux control bit 2 picks extended RAM size, 256 or 512 bytes.
// - Aux control bit 1 routes data moves to internal RAM or external memory.
// - External select bit loads from security byte after power-up.
// - Bit 0 clear: latch strobe runs at 1/6 clock, 1/3 double speed.
// - Bit 0 set: latch strobe pulses only during data moves or table reads.
// - Aux control reset clears bits 7, 2, 1 and 0.
// - Boot enable set maps boot ROM at 8000h-FFFFh for fetches.
// - Boot enable clear sends fetches past 7FFFh to external code.
// - Reset forces boot enable to one.
// - Second aux bit 3 is a plain software flag.
// - Second aux bit 0 selects the active data pointer, reset zero.
// - Second aux bit 2 always reads zero so increment toggles pointer select.
// - Code-RAM variant resets boot enable to one and pointer select zero.
// - Small variant has no boot enable; reset clears pointer select and user flag.
// - Code map bit set sends data move writes into code RAM.
// - Code map bit clear keeps data moves off code RAM.
// - Code map bit overrides the external select bit.
// - Code map register reset clears its mapping bit.
// - With code map bit clear, wide-pointer data above internal RAM size rolls over to external memory.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

`include "mmc_defines.svh"

module mmc_memory_map_regs #(
  parameter bit HAS_BOOT_ROM = 1'b1
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_B_I,
  input  wire logic        CE_I,
  // Register port
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  // Straps and core status
  input  wire logic        SEC_EXT_DATA_I,
  input  wire logic        DOUBLE_SPEED_I,
  // Data move and fetch requests from the core
  input  wire logic        DATA_MOVE_I,
  input  wire logic        TABLE_READ_I,
  input  wire logic        WIDE_PTR_I,
  input  wire logic [15:0] DATA_ADDR_I,
  input  wire logic [15:0] FETCH_ADDR_I,
  // Steering outputs
  output logic             PULLUP_DISABLE_O,
  output logic             POINTER_SELECT_O,
  output logic             USER_FLAG_O,
  output logic [1:0]       DATA_DST_O,
  output logic [1:0]       FETCH_DST_O,
  output logic             LATCH_STROBE_O
);

  // ****************************************************************
  // Reset synchroniser
  // ****************************************************************
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ****************************************************************
  // Register decode
  // ****************************************************************
  logic wr_mem;
  logic wr_boot;
  logic wr_map;

  assign wr_mem  = WR_I && (ADDR_I == `MMC_OFS_AUX_MEM);
  assign wr_boot = WR_I && (ADDR_I == `MMC_OFS_AUX_BOOT);
  assign wr_map  = WR_I && (ADDR_I == `MMC_OFS_CODE_MAP);

  // ****************************************************************
  // Storage bits
  // ****************************************************************
  logic pullup_disable;
  logic ext_ram_size_sel;
  logic external_data_sel_r;
  logic latch_strobe_gate;
  logic boot_rom_enable;
  logic user_flag;
  logic pointer_select;
  logic code_ram_map_sel;

  mmc_cfg_bit #(.RST_VAL(1'b0)) u_pullup (
    .clk_i   (CLOCK_I),
    .rst_b_i (rst_sync_r),
    .ce_i    (CE_I),
    .load_i  (wr_mem),
    .din_i   (WDATA_I[`MMC_BIT_PULLUP_DIS]),
    .q_o     (pullup_disable)
  );

  mmc_cfg_bit #(.RST_VAL(1'b0)) u_ramsize (
    .clk_i   (CLOCK_I),
    .rst_b_i (rst_sync_r),
    .ce_i    (CE_I),
    .load_i  (wr_mem),
    .din_i   (WDATA_I[`MMC_BIT_RAM_SIZE]),
    .q_o     (ext_ram_size_sel)
  );

  mmc_cfg_bit #(.RST_VAL(1'b0)) u_gate (
    .clk_i   (CLOCK_I),
    .rst_b_i (rst_sync_r),
    .ce_i    (CE_I),
    .load_i  (wr_mem),
    .din_i   (WDATA_I[`MMC_BIT_LATCH_GATE]),
    .q_o     (latch_strobe_gate)
  );

  mmc_cfg_bit #(.RST_VAL(1'b0)) u_flag (
    .clk_i   (CLOCK_I),
    .rst_b_i (rst_sync_r),
    .ce_i    (CE_I),
    .load_i  (wr_boot),
    .din_i   (WDATA_I[`MMC_BIT_USER_FLAG]),
    .q_o     (user_flag)
  );

  mmc_cfg_bit #(.RST_VAL(1'b0)) u_ptrsel (
    .clk_i   (CLOCK_I),
    .rst_b_i (rst_sync_r),
    .ce_i    (CE_I),
    .load_i  (wr_boot),
    .din_i   (WDATA_I[`MMC_BIT_PTR_SEL]),
    .q_o     (pointer_select)
  );

  mmc_cfg_bit #(.RST_VAL(1'b0)) u_map (
    .clk_i   (CLOCK_I),
    .rst_b_i (rst_sync_r),
    .ce_i    (CE_I),
    .load_i  (wr_map),
    .din_i   (WDATA_I[`MMC_BIT_CODE_MAP]),
    .q_o     (code_ram_map_sel)
  );

  generate
    if (HAS_BOOT_ROM) begin : g_boot
      mmc_cfg_bit #(.RST_VAL(`MMC_RST_BOOT_EN)) u_boot (
        .clk_i   (CLOCK_I),
        .rst_b_i (rst_sync_r),
        .ce_i    (CE_I),
        .load_i  (wr_boot),
        .din_i   (WDATA_I[`MMC_BIT_BOOT_EN]),
        .q_o     (boot_rom_enable)
      );
    end else begin : g_noboot
      assign boot_rom_enable = 1'b0;
    end
  endgenerate

  // Security byte is sampled once after reset release, not through the async reset path
  logic sec_loaded_r;

  always_ff @(posedge CLOCK_I or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sec_loaded_r        <= 1'b0;
      external_data_sel_r <= 1'b0;
    end else if (CE_I) begin
      if (!sec_loaded_r) begin
        sec_loaded_r        <= 1'b1;
        external_data_sel_r <= SEC_EXT_DATA_I;
      end else if (wr_mem) begin
        external_data_sel_r <= WDATA_I[`MMC_BIT_EXT_DATA];
      end
    end
  end

  // Write and reset checks on the storage bits
  AST_PULLUP_WRITE: assert property (@(posedge CLOCK_I) disable iff (!rst_sync_r)
    (CE_I && wr_mem) |=> (PULLUP_DISABLE_O == $past(WDATA_I[`MMC_BIT_PULLUP_DIS])))
    else $error("pull-up disable bit did not take the written value");

  AST_RAM_SIZE_WRITE: assert property (@(posedge CLOCK_I) disable iff (!rst_sync_r)
    (CE_I && wr_mem) |=> (ext_ram_size_sel == $past(WDATA_I[`MMC_BIT_RAM_SIZE])))
    else $error("RAM size bit did not take the written value");

  // The first enabled edge after reset belongs to the security load, so a write there is not checked
  AST_EXT_SEL_WRITE: assert property (@(posedge CLOCK_I) disable iff (!rst_sync_r)
    (CE_I && wr_mem && sec_loaded_r) |=> (external_data_sel_r == $past(WDATA_I[`MMC_BIT_EXT_DATA])))
    else $error("external select bit did not take the written value");

  // The security strap is taken at the first enabled edge after every reset
  AST_SEC_LOAD: assert property (@(posedge CLOCK_I) disable iff (!rst_sync_r)
    (rst_sync_r && CE_I && !sec_loaded_r) |=> (external_data_sel_r == $past(SEC_EXT_DATA_I)))
    else $error("external select bit did not load the security strap");

  // Sampled at the first edge after the internal reset lets go, before any write can land
  AST_AUX_RESET: assert property (@(posedge CLOCK_I)
    $rose(rst_sync_r) |-> (!pullup_disable && !ext_ram_size_sel && !external_data_sel_r && !latch_strobe_gate))
    else $error("aux control bits not clear after reset");

  AST_BOOT_RESET: assert property (@(posedge CLOCK_I)
    $rose(rst_sync_r) |-> ((boot_rom_enable == HAS_BOOT_ROM) && !pointer_select && !code_ram_map_sel))
    else $error("boot enable, pointer select or code map bit wrong after reset");

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Reserved positions read as zero; software must not rely on them
  logic [7:0] rd_nxt;

  always_comb begin
    rd_nxt = 8'h00;
    case (ADDR_I)
      `MMC_OFS_AUX_MEM: begin
        rd_nxt[`MMC_BIT_PULLUP_DIS] = pullup_disable;
        rd_nxt[`MMC_BIT_RAM_SIZE]   = ext_ram_size_sel;
        rd_nxt[`MMC_BIT_EXT_DATA]   = external_data_sel_r;
        rd_nxt[`MMC_BIT_LATCH_GATE] = latch_strobe_gate;
      end
      `MMC_OFS_AUX_BOOT: begin
        rd_nxt[`MMC_BIT_BOOT_EN]    = boot_rom_enable;
        rd_nxt[`MMC_BIT_USER_FLAG]  = user_flag;
        rd_nxt[`MMC_BIT_ZERO]       = 1'b0;
        rd_nxt[`MMC_BIT_PTR_SEL]    = pointer_select;
      end
      `MMC_OFS_CODE_MAP: begin
        rd_nxt[`MMC_BIT_CODE_MAP]   = code_ram_map_sel;
      end
      default: begin
        rd_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      RDATA_O <= 8'h00;
    end else if (CE_I) begin
      RDATA_O <= RD_I ? rd_nxt : 8'h00;
    end
  end

  // Bit 2 reads clear so an increment carry stops below it and never reaches the user flag
  AST_POINTER_READ: assert property (@(posedge CLOCK_I) disable iff (!rst_sync_r)
    (CE_I && RD_I && (ADDR_I == `MMC_OFS_AUX_BOOT)) |=>
      (!RDATA_O[`MMC_BIT_ZERO] && (RDATA_O[`MMC_BIT_PTR_SEL] == $past(pointer_select))))
    else $error("pointer register read shows bit 2 set or a stale pointer select");

  // ****************************************************************
  // Routing
  // ****************************************************************
  logic [15:0] ram_end;
  logic        above_ram;
  logic        data_dst_ext;

  assign ram_end   = ext_ram_size_sel ? `MMC_RAM_END_LARGE : `MMC_RAM_END_SMALL;
  // Narrow register-indirect moves only carry eight address bits, so they never roll over
  assign above_ram = WIDE_PTR_I && (DATA_ADDR_I > ram_end);
  assign data_dst_ext = external_data_sel_r || above_ram;

  always_comb begin
    if (code_ram_map_sel) begin
      DATA_DST_O = mmc_pkg::MMC_DST_CODE_RAM;
    end else if (data_dst_ext) begin
      DATA_DST_O = mmc_pkg::MMC_DST_EXT_DATA;
    end else begin
      DATA_DST_O = mmc_pkg::MMC_DST_INT_RAM;
    end
  end

  always_comb begin
    if (FETCH_ADDR_I <= `MMC_CODE_TOP_LOW) begin
      FETCH_DST_O = mmc_pkg::MMC_FETCH_LOW_CODE;
    end else if (boot_rom_enable) begin
      FETCH_DST_O = mmc_pkg::MMC_FETCH_BOOT_ROM;
    end else begin
      FETCH_DST_O = mmc_pkg::MMC_FETCH_EXT_CODE;
    end
  end

  AST_ROLL_OVER: assert property (@(posedge CLOCK_I) disable iff (!rst_sync_r)
    (!code_ram_map_sel && WIDE_PTR_I && (DATA_ADDR_I > `MMC_RAM_END_LARGE)) |->
      (DATA_DST_O == mmc_pkg::MMC_DST_EXT_DATA))
    else $error("wide move above the extended RAM did not go external");

  AST_FETCH_BOOT: assert property (@(posedge CLOCK_I) disable iff (!rst_sync_r)
    (boot_rom_enable && (FETCH_ADDR_I > `MMC_CODE_TOP_LOW)) |-> (FETCH_DST_O == mmc_pkg::MMC_FETCH_BOOT_ROM))
    else $error("upper fetch did not go to the boot ROM");

  AST_FETCH_EXT: assert property (@(posedge CLOCK_I) disable iff (!rst_sync_r)
    (!boot_rom_enable && (FETCH_ADDR_I > `MMC_CODE_TOP_LOW)) |-> (FETCH_DST_O == mmc_pkg::MMC_FETCH_EXT_CODE))
    else $error("upper fetch did not go to external code");

  // Cover points for the main routing scenarios
  COV_CODE_RAM_MOVE: cover property (@(posedge CLOCK_I) disable iff (!rst_sync_r)
    DATA_MOVE_I && (DATA_DST_O == mmc_pkg::MMC_DST_CODE_RAM));
  COV_BOOT_FETCH: cover property (@(posedge CLOCK_I) disable iff (!rst_sync_r)
    FETCH_DST_O == mmc_pkg::MMC_FETCH_BOOT_ROM);

  assign PULLUP_DISABLE_O = pullup_disable;
  assign POINTER_SELECT_O = pointer_select;
  assign USER_FLAG_O      = user_flag;

  // ****************************************************************
  // Address latch strobe
  // ****************************************************************
  mmc_strobe_gen u_strobe (
    .clk_i          (CLOCK_I),
    .rst_b_i        (rst_sync_r),
    .ce_i           (CE_I),
    .gate_i         (latch_strobe_gate),
    .double_speed_i (DOUBLE_SPEED_I),
    .ext_access_i   (DATA_MOVE_I || TABLE_READ_I),
    .strobe_o       (LATCH_STROBE_O)
  );

  // The edge right after the gate opens may follow a gated pulse, so the cycle before must be free-running too
  AST_STROBE_SINGLE: assert property (@(posedge CLOCK_I) disable iff (!rst_sync_r)
    (CE_I && !latch_strobe_gate && $past(CE_I) && !$past(latch_strobe_gate) && LATCH_STROBE_O) |=>
      !LATCH_STROBE_O)
    else $error("free-running latch strobe held high for more than one cycle");

  AST_STROBE_GATED: assert property (@(posedge CLOCK_I) disable iff (!rst_sync_r)
    (CE_I && latch_strobe_gate) |=> (LATCH_STROBE_O == ($past(DATA_MOVE_I) || $past(TABLE_READ_I))))
    else $error("gated latch strobe did not follow the move or table read");

  // Cover points for both strobe modes
  COV_STROBE_GATED: cover property (@(posedge CLOCK_I) disable iff (!rst_sync_r)
    latch_strobe_gate && LATCH_STROBE_O);
  COV_STROBE_DOUBLE: cover property (@(posedge CLOCK_I) disable iff (!rst_sync_r)
    DOUBLE_SPEED_I && LATCH_STROBE_O);

endmodule // mmc_memory_map_regs

`default_nettype wire

//--- verif/memory_map_config_regs_tb.sv
// Self-checking bench for the memory map configuration registers
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; $display("mismatch %s exp %h got %h", nm, ex, got); end end

module memory_map_config_regs_tb;
  typedef struct {
    logic [7:0]  mem, boot, cmap;
    logic        wide;
    logic [15:0] da, fa;
    logic [1:0]  dd, fd;
  } mmc_row_t;

  logic        CLOCK_I = 1'b0, RST_B_I = 1'b0, CE_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0;
  logic [7:0]  ADDR_I = 8'h00, WDATA_I = 8'h00, RDATA_O, v;
  logic        SEC_EXT_DATA_I = 1'b0, DOUBLE_SPEED_I = 1'b0, DATA_MOVE_I = 1'b0;
  logic        TABLE_READ_I = 1'b0, WIDE_PTR_I = 1'b0;
  logic [15:0] DATA_ADDR_I = 16'h0000, FETCH_ADDR_I = 16'h0000;
  logic        PULLUP_DISABLE_O, POINTER_SELECT_O, USER_FLAG_O, LATCH_STROBE_O;
  logic [1:0]  DATA_DST_O, FETCH_DST_O;
  int          num_errors = 0, check_count = 0, rises, highs;

  // Routing rows: aux, boot, code map, wide, data addr, fetch addr, data dst, fetch dst
  mmc_row_t rows [8] = '{
    '{8'h00, 8'h20, 8'h00, 1'b0, 16'h0080, 16'h7FFF, 2'h0, 2'h0},
    '{8'h00, 8'h20, 8'h00, 1'b1, 16'h0100, 16'h8000, 2'h1, 2'h1},
    '{8'h04, 8'h00, 8'h00, 1'b1, 16'h01FF, 16'hFFFF, 2'h0, 2'h2},
    '{8'h04, 8'h00, 8'h00, 1'b1, 16'h0200, 16'h0000, 2'h1, 2'h0},
    '{8'h02, 8'h20, 8'h00, 1'b0, 16'h0010, 16'h8001, 2'h1, 2'h1},
    '{8'h02, 8'h00, 8'h08, 1'b1, 16'h0300, 16'h9000, 2'h2, 2'h2},
    '{8'h00, 8'h20, 8'h08, 1'b0, 16'h0010, 16'h7000, 2'h2, 2'h0},
    '{8'h87, 8'h29, 8'h08, 1'b1, 16'h0020, 16'hC000, 2'h2, 2'h1}
  };

  always #25 CLOCK_I = ~CLOCK_I;

  mmc_memory_map_regs #(.HAS_BOOT_ROM(1'b1)) i_dut (
    .CLOCK_I          (CLOCK_I),
    .RST_B_I          (RST_B_I),
    .CE_I             (CE_I),
    .ADDR_I           (ADDR_I),
    .WDATA_I          (WDATA_I),
    .WR_I             (WR_I),
    .RD_I             (RD_I),
    .RDATA_O          (RDATA_O),
    .SEC_EXT_DATA_I   (SEC_EXT_DATA_I),
    .DOUBLE_SPEED_I   (DOUBLE_SPEED_I),
    .DATA_MOVE_I      (DATA_MOVE_I),
    .TABLE_READ_I     (TABLE_READ_I),
    .WIDE_PTR_I       (WIDE_PTR_I),
    .DATA_ADDR_I      (DATA_ADDR_I),
    .FETCH_ADDR_I     (FETCH_ADDR_I),
    .PULLUP_DISABLE_O (PULLUP_DISABLE_O),
    .POINTER_SELECT_O (POINTER_SELECT_O),
    .USER_FLAG_O      (USER_FLAG_O),
    .DATA_DST_O       (DATA_DST_O),
    .FETCH_DST_O      (FETCH_DST_O),
    .LATCH_STROBE_O   (LATCH_STROBE_O)
  );

  // ****************************************
  // Bus and helper tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK_I);
    ADDR_I  <= a;
    WDATA_I <= d;
    WR_I    <= 1'b1;
    @(posedge CLOCK_I);
    WR_I    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge CLOCK_I);
    ADDR_I <= a;
    RD_I   <= 1'b1;
    @(posedge CLOCK_I);
    RD_I   <= 1'b0;
    @(negedge CLOCK_I);
    v = RDATA_O;
  endtask

  task automatic rst(input logic sec);
    @(posedge CLOCK_I);
    RST_B_I        <= 1'b0;
    SEC_EXT_DATA_I <= sec;
    repeat (10) @(posedge CLOCK_I);
    RST_B_I        <= 1'b1;
    repeat (3) @(posedge CLOCK_I);
  endtask

  task automatic chk_rst(input logic sec);
    rd(8'h8E); `CHK("aux_mem_rst", {6'h00, sec, 1'b0}, v)
    rd(8'hA2); `CHK("aux_boot_rst", 8'h20, v)
    rd(8'hD1); `CHK("code_map_rst", 8'h00, v)
    `CHK("pullup_rst", 1'b0, PULLUP_DISABLE_O)
    `CHK("ptr_rst", 1'b0, POINTER_SELECT_O)
  endtask

  // Settles a few cycles first, so a divider change does not skew the count
  task automatic cnt(input int n);
    logic p;
    repeat (8) @(negedge CLOCK_I);
    p     = LATCH_STROBE_O;
    rises = 0;
    highs = 0;
    repeat (n) begin
      @(negedge CLOCK_I);
      rises += (!p && LATCH_STROBE_O) ? 1 : 0;
      highs += LATCH_STROBE_O ? 1 : 0;
      p     = LATCH_STROBE_O;
    end
  endtask

  task automatic results();
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst(1'b0);
    foreach (rows[i]) begin
      wr(8'h8E, rows[i].mem);
      wr(8'hA2, rows[i].boot);
      wr(8'hD1, rows[i].cmap);
      WIDE_PTR_I   <= rows[i].wide;
      DATA_ADDR_I  <= rows[i].da;
      FETCH_ADDR_I <= rows[i].fa;
      DATA_MOVE_I  <= 1'b1;
      rd(8'h8E); `CHK("aux_mem", rows[i].mem & 8'h87, v)
      rd(8'hA2); `CHK("aux_boot", rows[i].boot & 8'h29, v)
      rd(8'hD1); `CHK("code_map", rows[i].cmap & 8'h08, v)
      `CHK("pullup", rows[i].mem[7], PULLUP_DISABLE_O)
      `CHK("ptr_sel", rows[i].boot[0], POINTER_SELECT_O)
      `CHK("user_flag", rows[i].boot[3], USER_FLAG_O)
      `CHK("data_dst", rows[i].dd, DATA_DST_O)
      `CHK("fetch_dst", rows[i].fd, FETCH_DST_O)
    end
    @(posedge CLOCK_I);
    DATA_MOVE_I <= 1'b0;
    wr(8'h55, 8'hFF);
    rd(8'h55); `CHK("unmapped", 8'h00, v)
    @(posedge CLOCK_I);
    CE_I <= 1'b0;
    wr(8'h8E, 8'h00);
    CE_I <= 1'b1;
    rd(8'h8E); `CHK("ce_hold", 8'h87, v)
    // Increment of the pointer register, as software toggles the pointer
    wr(8'hA2, 8'h28);
    rd(8'hA2);
    wr(8'hA2, v + 8'h01);
    rd(8'hA2); `CHK("inc_one", 8'h29, v)
    wr(8'hA2, v + 8'h01);
    rd(8'hA2); `CHK("inc_two", 8'h28, v)
    `CHK("flag_kept", 1'b1, USER_FLAG_O)
    wr(8'h8E, 8'h00);
    cnt(60); `CHK("strobe_x1", 10, rises)
    @(posedge CLOCK_I);
    DOUBLE_SPEED_I <= 1'b1;
    cnt(60); `CHK("strobe_x2", 20, rises)
    @(posedge CLOCK_I);
    DOUBLE_SPEED_I <= 1'b0;
    wr(8'h8E, 8'h01);
    cnt(30); `CHK("strobe_idle", 0, rises)
    fork
      begin
        repeat (9) @(posedge CLOCK_I);
        DATA_MOVE_I  <= 1'b1;
        repeat (3) @(posedge CLOCK_I);
        DATA_MOVE_I  <= 1'b0;
        TABLE_READ_I <= 1'b1;
        repeat (3) @(posedge CLOCK_I);
        TABLE_READ_I <= 1'b0;
      end
      cnt(14);
    join
    `CHK("strobe_moves", 6, highs)
    rst(1'b1);
    chk_rst(1'b1);
    @(posedge CLOCK_I);
    DATA_MOVE_I <= 1'b1;
    WIDE_PTR_I  <= 1'b0;
    DATA_ADDR_I <= 16'h0010;
    @(negedge CLOCK_I);
    `CHK("dst_sec", 2'h1, DATA_DST_O)
    rst(1'b0);
    chk_rst(1'b0);
    results();
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge CLOCK_I);
    num_errors++;
    results();
  end
endmodule // memory_map_config_regs_tb

`default_nettype wire
